// File: hw/hdu_uart.sv
`timescale 1ns/1ps
module hdu_uart (
  input  wire logic                  clk,              // System clock, 10 MHz
  input  wire logic                  rst_n,            // Async reset, active low
  input  wire hdu_pkg::hdu_bus_req_t bus_req,          // Register port request
  output logic [7:0]                 bus_rdata,        // Read data, cycle after read
  input  wire logic                  serial_in,        // Receive line
  input  wire logic                  port_data_bit,    // Port register bit of pin
  output logic                       serial_out_pin,   // Transmit pin
  output logic                       tx_output_select, // High while transmitting
  output logic                       tx_irq,           // Transmit interrupt level
  output logic                       rx_irq            // Receive interrupt level
);
  import hdu_pkg::*;

  hdu_ctrl_t  ctrl_reg;
  logic [7:0] rx_buf_reg;
  logic [8:0] tx_shift_reg;
  logic [8:0] rx_shift_reg;
  hdu_phase_t tx_state_reg;
  hdu_phase_t rx_state_reg;
  logic [2:0] phase_reg;
  logic [3:0] bit_cnt_reg;
  logic [2:0] samp_reg;
  logic       rx_prev_reg;

  logic       tick;
  logic       restart;
  logic       tx_start;
  logic       ctrl_wr;
  logic       bit_end;
  logic       rx_fall;
  logic       rx_begin;
  logic       rx_done;
  logic       tx_done;
  logic       vote;
  logic       tx_line;
  logic       tx_active;

  // Bus decode
  assign tx_start = bus_req.wr && (bus_req.addr == ADDR_DATA);
  assign ctrl_wr  = bus_req.wr && (bus_req.addr == ADDR_CTRL);

  // Baud state ticks come from the free-running system clock, which has no
  // gating of its own, so reception and transmission go on in wait mode
  hdu_baud_div u_baud_div (
    .clk         (clk),
    .rst_n       (rst_n),
    .baud_select (ctrl_reg.baud_select),
    .restart     (restart),
    .tick        (tick)
  );

  assign tx_active = (tx_state_reg != BIT_IDLE);

  // The receiver only looks for a start edge while no character goes out
  assign rx_fall  = rx_prev_reg && !serial_in;
  assign rx_begin = rx_fall && !tx_active && (rx_state_reg == BIT_IDLE)
                    && !tx_start;

  // Realign the bit grid to the start of each character
  assign restart = tx_start || rx_begin;
  assign bit_end = tick && (phase_reg == STATE_LAST);

  // Two of three samples decide the bit level
  assign vote = (samp_reg[0] & samp_reg[1]) | (samp_reg[0] & samp_reg[2])
                | (samp_reg[1] & samp_reg[2]);

  assign rx_done = bit_end && (rx_state_reg == BIT_STOP) && !tx_start;
  assign tx_done = bit_end && (tx_state_reg == BIT_STOP);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_prev_reg <= 1'b1;
    end
    else
    begin
      rx_prev_reg <= serial_in;
    end
  end

  // State counter within a bit, shared since only one direction is active
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_reg <= '0;
    end
    else if (restart)
    begin
      phase_reg <= '0;
    end
    else if (tick)
    begin
      phase_reg <= phase_reg + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bit_cnt_reg <= '0;
    end
    else if (restart)
    begin
      bit_cnt_reg <= '0;
    end
    else if (bit_end && ((tx_state_reg == BIT_DATA) || (rx_state_reg == BIT_DATA)))
    begin
      bit_cnt_reg <= bit_cnt_reg + 1'b1;
    end
    else if (bit_end)
    begin
      bit_cnt_reg <= '0;
    end
  end

  // Vote samples, taken at three middle states of each bit
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      samp_reg <= 3'h7;
    end
    else if (tick)
    begin
      case (phase_reg)
        SAMPLE_A: samp_reg[0] <= serial_in;
        SAMPLE_B: samp_reg[1] <= serial_in;
        SAMPLE_C: samp_reg[2] <= serial_in;
        default:  samp_reg    <= samp_reg;
      endcase
    end
  end

  // Transmitter
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_state_reg <= BIT_IDLE;
      tx_shift_reg <= SHIFT_RESET;
    end
    else if (tx_start)
    begin
      tx_state_reg <= BIT_START;
      tx_shift_reg <= {ctrl_reg.ninth_bit, bus_req.wdata};
    end
    else if (bit_end)
    begin
      case (tx_state_reg)
        BIT_START:
        begin
          tx_state_reg <= BIT_DATA;
        end
        BIT_DATA:
        begin
          // Lsb first, ninth bit last
          tx_shift_reg <= {1'b0, tx_shift_reg[8:1]};
          if (bit_cnt_reg == DATA_BITS_LAST)
          begin
            tx_state_reg <= BIT_STOP;
          end
        end
        BIT_STOP:
        begin
          tx_state_reg <= BIT_IDLE;
        end
        default:
        begin
          tx_state_reg <= BIT_IDLE;
        end
      endcase
    end
  end

  always_comb
  begin
    case (tx_state_reg)
      BIT_START: tx_line = 1'b0;
      BIT_DATA:  tx_line = tx_shift_reg[0];
      BIT_STOP:  tx_line = 1'b1;
      default:   tx_line = 1'b1;
    endcase
  end

  // Receiver
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_state_reg <= BIT_IDLE;
      rx_shift_reg <= SHIFT_RESET;
    end
    else if (tx_start)
    begin
      // Transmission takes over the shared counters at once
      rx_state_reg <= BIT_IDLE;
    end
    else if (rx_begin)
    begin
      rx_state_reg <= BIT_START;
    end
    else if (bit_end)
    begin
      case (rx_state_reg)
        BIT_START:
        begin
          // Start bit level is not rechecked; a glitch yields a junk character
          rx_state_reg <= BIT_DATA;
        end
        BIT_DATA:
        begin
          rx_shift_reg <= {vote, rx_shift_reg[8:1]};
          if (bit_cnt_reg == DATA_BITS_LAST)
          begin
            rx_state_reg <= BIT_STOP;
          end
        end
        BIT_STOP:
        begin
          // Stop level is not validated; there is no framing error flag
          rx_state_reg <= BIT_IDLE;
        end
        default:
        begin
          rx_state_reg <= BIT_IDLE;
        end
      endcase
    end
  end

  // Receive buffer, loaded only when a whole character has arrived
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_buf_reg <= RXBUF_RESET;
    end
    else if (rx_done)
    begin
      rx_buf_reg <= rx_shift_reg[7:0];
    end
  end

  // Enables and baud select are plain software fields
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_reg.rx_irq_enable <= CTRL_RESET[5];
      ctrl_reg.tx_irq_enable <= CTRL_RESET[4];
      ctrl_reg.baud_select   <= CTRL_RESET[3:1];
    end
    else if (ctrl_wr)
    begin
      ctrl_reg.rx_irq_enable <= bus_req.wdata[5];
      ctrl_reg.tx_irq_enable <= bus_req.wdata[4];
      // Takes effect at once, even mid-character
      ctrl_reg.baud_select   <= bus_req.wdata[3:1];
    end
  end

  // Ninth bit: a received character wins over a same-cycle write
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_reg.ninth_bit <= CTRL_RESET[0];
    end
    else if (rx_done)
    begin
      ctrl_reg.ninth_bit <= rx_shift_reg[8];
    end
    else if (ctrl_wr)
    begin
      ctrl_reg.ninth_bit <= bus_req.wdata[0];
    end
  end

  // Receiver ready: hardware set wins over a written zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_reg.rx_ready_flag <= CTRL_RESET[7];
    end
    else if (rx_done)
    begin
      ctrl_reg.rx_ready_flag <= 1'b1;
    end
    else if (ctrl_wr)
    begin
      ctrl_reg.rx_ready_flag <= bus_req.wdata[7];
    end
  end

  // Transmitter empty: end of stop wins, then data write, then control write
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_reg.tx_empty_flag <= CTRL_RESET[6];
    end
    else if (tx_done)
    begin
      ctrl_reg.tx_empty_flag <= 1'b1;
    end
    else if (tx_start)
    begin
      ctrl_reg.tx_empty_flag <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      // Writing one raises a software interrupt if enabled
      ctrl_reg.tx_empty_flag <= bus_req.wdata[6];
    end
  end

  // Read data stand only in the cycle after the read strobe
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_rdata <= 8'h00;
    end
    else if (bus_req.rd && (bus_req.addr == ADDR_DATA))
    begin
      bus_rdata <= rx_buf_reg;
    end
    else if (bus_req.rd && (bus_req.addr == ADDR_CTRL))
    begin
      bus_rdata <= ctrl_reg;
    end
    else
    begin
      bus_rdata <= 8'h00;
    end
  end

  // Pin multiplexer, registered so the pin never glitches
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_output_select <= 1'b0;
      serial_out_pin   <= 1'b0;
    end
    else
    begin
      tx_output_select <= tx_active;
      if (tx_active)
      begin
        // An external one-transistor stage inverts it back
        serial_out_pin <= ~tx_line;
      end
      else
      begin
        // Idle level relies on software holding this port bit high
        serial_out_pin <= port_data_bit;
      end
    end
  end

  // Interrupt levels follow the flags while enabled
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_irq <= 1'b0;
      rx_irq <= 1'b0;
    end
    else
    begin
      tx_irq <= ctrl_reg.tx_empty_flag && ctrl_reg.tx_irq_enable;
      rx_irq <= ctrl_reg.rx_ready_flag && ctrl_reg.rx_irq_enable;
    end
  end

endmodule : hdu_uart

// File: hw/hdu_pkg.sv
package hdu_pkg;

  // Register addresses on the local register port
  localparam logic [7:0] ADDR_DATA = 8'hD6;
  localparam logic [7:0] ADDR_CTRL = 8'hD7;

  // Reset values
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [7:0] RXBUF_RESET = 8'h00;
  localparam logic [8:0] SHIFT_RESET = 9'h000;

  // Bit timing: eight states per bit, three vote samples
  localparam logic [2:0] STATE_LAST = 3'h7;
  localparam logic [2:0] SAMPLE_A   = 3'h3;
  localparam logic [2:0] SAMPLE_B   = 3'h4;
  localparam logic [2:0] SAMPLE_C   = 3'h5;
  localparam int         STATES_PER_BIT = 8;

  // Nine data bits per character, counted from zero
  localparam logic [3:0] DATA_BITS_LAST = 4'h8;

  // Internal clock divisors per baud select code
  localparam int DIV_SEL0 = 6656;
  localparam int DIV_SEL1 = 3328;
  localparam int DIV_SEL2 = 1664;
  localparam int DIV_SEL3 = 832;
  localparam int DIV_SEL4 = 416;
  localparam int DIV_SEL5 = 256;
  localparam int DIV_SEL6 = 208;
  localparam int DIV_W    = 10;

  typedef logic [2:0] hdu_baud_sel_t;

  // Control register layout, msb first
  typedef struct packed {
    logic          rx_ready_flag;
    logic          tx_empty_flag;
    logic          rx_irq_enable;
    logic          tx_irq_enable;
    hdu_baud_sel_t baud_select;
    logic          ninth_bit;
  } hdu_ctrl_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } hdu_bus_req_t;

  typedef enum logic [1:0] {
    BIT_IDLE,
    BIT_START,
    BIT_DATA,
    BIT_STOP
  } hdu_phase_t;

endpackage : hdu_pkg

// File: hw/hdu_baud_div.sv
`timescale 1ns/1ps
module hdu_baud_div (
  input  wire logic                   clk,         // System clock
  input  wire logic                   rst_n,       // Async reset, active low
  input  wire hdu_pkg::hdu_baud_sel_t baud_select, // Divisor code
  input  wire logic                   restart,     // Realign to a bit edge
  output logic                        tick         // One pulse per bit state
);
  import hdu_pkg::*;

  logic [DIV_W-1:0] cnt_reg;
  logic [DIV_W-1:0] limit;

  // Eight ticks make one bit, so each state is a divisor over eight
  always_comb
  begin
    case (baud_select)
      3'h0: limit = DIV_W'(DIV_SEL0 / STATES_PER_BIT - 1);
      3'h1: limit = DIV_W'(DIV_SEL1 / STATES_PER_BIT - 1);
      3'h2: limit = DIV_W'(DIV_SEL2 / STATES_PER_BIT - 1);
      3'h3: limit = DIV_W'(DIV_SEL3 / STATES_PER_BIT - 1);
      3'h4: limit = DIV_W'(DIV_SEL4 / STATES_PER_BIT - 1);
      3'h5: limit = DIV_W'(DIV_SEL5 / STATES_PER_BIT - 1);
      3'h6: limit = DIV_W'(DIV_SEL6 / STATES_PER_BIT - 1);
      default: limit = DIV_W'(DIV_SEL0 / STATES_PER_BIT - 1);
    endcase
  end

  // Compare with >= so a live change to a lower divisor cannot stall
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end
    else if (restart)
    begin
      // The tick flop adds one clock, so a restart starts one count in
      cnt_reg <= DIV_W'(1);
      tick    <= 1'b0;
    end
    else if (cnt_reg >= limit)
    begin
      cnt_reg <= '0;
      tick    <= 1'b1;
    end
    else
    begin
      cnt_reg <= cnt_reg + 1'b1;
      tick    <= 1'b0;
    end
  end

endmodule : hdu_baud_div

// File: verif/hdu_uart_monitor.sv
`timescale 1ns/1ps
module hdu_uart_chk (
  input wire logic                  clk,              // Clock
  input wire logic                  rst_n,            // Reset, active low
  input wire hdu_pkg::hdu_bus_req_t bus_req,          // Register request
  input wire logic [7:0]            bus_rdata,        // Read data
  input wire logic                  serial_in,        // Receive line
  input wire logic                  port_data_bit,    // Port bit
  input wire logic                  serial_out_pin,   // Transmit pin
  input wire logic                  tx_output_select, // Transmit active
  input wire logic                  tx_irq,           // Transmit interrupt
  input wire logic                  rx_irq            // Receive interrupt
);
  import hdu_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence data_wr_s;
    bus_req.wr && bus_req.addr == ADDR_DATA;
  endsequence
  sequence ctrl_wr_s;
    bus_req.wr && bus_req.addr == ADDR_CTRL;
  endsequence
  tx_start_a: assert property (data_wr_s |-> ##2 tx_output_select && serial_out_pin)
    else $error("transmit start missing");
  rdata_idle_a: assert property (!bus_req.rd |=> bus_rdata == 8'h00)
    else $error("read data outside read slot");
  unmapped_rd_a: assert property (bus_req.rd && bus_req.addr != ADDR_DATA &&
    bus_req.addr != ADDR_CTRL |=> bus_rdata == 8'h00) else $error("unmapped read not zero");
  txirq_off_a: assert property (ctrl_wr_s ##0 !bus_req.wdata[4] |-> ##2 !tx_irq)
    else $error("tx irq while disabled");
  txirq_on_a: assert property (ctrl_wr_s ##0 (bus_req.wdata[6] && bus_req.wdata[4])
    |-> ##2 tx_irq) else $error("software tx irq missing");
  rxirq_on_a: assert property (ctrl_wr_s ##0 (bus_req.wdata[7] && bus_req.wdata[5])
    |-> ##2 rx_irq) else $error("rx irq missing after flag write");
  rxirq_off_a: assert property (ctrl_wr_s ##0 !bus_req.wdata[5] |-> ##2 !rx_irq)
    else $error("rx irq while disabled");
  idle_pin_a: assert property (!tx_output_select && !$past(tx_output_select) &&
    $past(rst_n) |-> serial_out_pin == $past(port_data_bit)) else $error("idle pin wrong");
  stop_level_a: assert property ($fell(tx_output_select) |-> !$past(serial_out_pin))
    else $error("stop bit not inverted");
endmodule : hdu_uart_chk
bind hdu_uart hdu_uart_chk u_chk (.clk(clk), .rst_n(rst_n), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .serial_in(serial_in), .port_data_bit(port_data_bit),
  .serial_out_pin(serial_out_pin), .tx_output_select(tx_output_select),
  .tx_irq(tx_irq), .rx_irq(rx_irq));

// File: verif/hdu_remote_node.sv
`timescale 1ns/1ps
module hdu_remote_node (
  input  wire logic        clk,      // Clock
  input  wire logic [12:0] bit_clks, // Clocks per bit
  input  wire logic        line_in,  // Line from the transceiver
  output logic             line_out  // Line into the transceiver
);
  logic [8:0] rx_word;
  logic       stop_ok;
  int         rx_count = 0;
  initial line_out = 1'h1;
  // Mid-bit sampling tolerates small rate offsets
  initial
  begin
    forever
    begin
      @(negedge line_in);
      repeat (bit_clks / 2) @(posedge clk);
      for (int i = 0; i < 9; i++)
      begin
        repeat (bit_clks) @(posedge clk);
        rx_word[i] = line_in;
      end
      repeat (bit_clks) @(posedge clk);
      stop_ok = line_in;
      rx_count++;
    end
  end
  // Any parity sits in the ninth bit, chosen by the caller
  task automatic send_char(input logic [8:0] ch);
    logic [10:0] frame;
    frame = {1'h1, ch, 1'h0};
    for (int i = 0; i < 11; i++)
    begin
      line_out <= frame[i];
      repeat (bit_clks) @(posedge clk);
    end
  endtask : send_char
endmodule : hdu_remote_node

// File: verif/hdu_uart_bench.sv
`timescale 1ns/1ps
module hdu_uart_bench;
  import hdu_pkg::*;
  typedef struct packed {
    logic       tx;
    logic [8:0] ch;
    logic [7:0] ctrl;
  } hdu_row_t;
  localparam hdu_row_t ROWS [4] = '{'{1'h1, 9'h155, 8'h7D}, '{1'h1, 9'h0A3, 8'h7C},
                                   '{1'h0, 9'h13C, 8'hBD}, '{1'h0, 9'h0C5, 8'hBC}};
  localparam int DIV_TAB [8] = '{DIV_SEL0, DIV_SEL1, DIV_SEL2, DIV_SEL3, DIV_SEL4,
                                 DIV_SEL5, DIV_SEL6, DIV_SEL0};
  logic         clk;
  logic         rst_n;
  hdu_bus_req_t bus_req;
  logic [7:0]   bus_rdata;
  logic         serial_in;
  logic         port_data_bit;
  logic         serial_out_pin;
  logic         tx_output_select;
  logic         tx_irq;
  logic         rx_irq;
  logic [7:0]   q;
  int           err_total = 0;
  int           cmp_count = 0;
  int           cyc = 0;
  int           n;
  int           k;
  hdu_uart u_dut (
    .clk(clk), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .serial_in(serial_in), .port_data_bit(port_data_bit),
    .serial_out_pin(serial_out_pin), .tx_output_select(tx_output_select),
    .tx_irq(tx_irq), .rx_irq(rx_irq)
  );
  // Inverting buffer stage; the line idles high outside frames
  hdu_remote_node u_node (
    .clk(clk), .bit_clks(13'h0D0), .line_in(~(serial_out_pin & tx_output_select)),
    .line_out(serial_in)
  );
  initial
  begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  task automatic end_sim();
    $display("checks %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      err_total++;
      $display("unexpected run length exp 60000 seen %0d", cyc);
      end_sim();
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected %s exp %h seen %h", what, exp, got);
    end
  endtask : chk
  // Every access leaves one idle cycle so no strobe is driven twice in a step
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    bus_req <= '{a, d, w, ~w};
    @(posedge clk);
    bus_req <= '0;
    @(negedge clk);
    q = bus_rdata;
    @(posedge clk);
  endtask : bus
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    bus(1'h0, a, 8'h00);
    chk(what, 16'(exp), 16'(q));
  endtask : rd_chk
  task automatic wait_for(input logic tx);
    k = 0;
    @(negedge clk);
    while ((tx ? tx_irq : rx_irq) !== 1'h1 && k < 3000)
    begin
      @(negedge clk);
      k++;
    end
    chk("irq in time", 16'h1, 16'(k < 3000));
    @(posedge clk);
  endtask : wait_for
  task automatic sent_chk(input logic [8:0] ch);
    chk("frames", 16'h1, 16'(u_node.rx_count - n));
    chk("sent char", {6'h0, 1'h1, ch}, {6'h0, u_node.stop_ok, u_node.rx_word});
  endtask : sent_chk
  task automatic irq_chk(input logic [1:0] exp);
    @(negedge clk);
    chk("irq pair", 16'(exp), 16'({tx_irq, rx_irq}));
    @(posedge clk);
  endtask : irq_chk
  initial
  begin
    rst_n = 1'h0;
    bus_req = '0;
    port_data_bit = 1'h1;
    repeat (15) @(posedge clk);
    @(negedge clk);
    chk("reset outs", 16'h0, 16'({serial_out_pin, tx_output_select, tx_irq, rx_irq}));
    @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    rd_chk("ctrl reset", ADDR_CTRL, CTRL_RESET);
    rd_chk("buf reset", ADDR_DATA, RXBUF_RESET);
    foreach (ROWS[i])
    begin
      n = u_node.rx_count;
      bus(1'h1, ADDR_CTRL, {4'h3, 3'h6, ROWS[i].ch[8] ^ ~ROWS[i].tx});
      if (ROWS[i].tx)
        bus(1'h1, ADDR_DATA, ROWS[i].ch[7:0]);
      else
        u_node.send_char(ROWS[i].ch);
      wait_for(ROWS[i].tx);
      if (ROWS[i].tx)
        sent_chk(ROWS[i].ch);
      rd_chk("ctrl", ADDR_CTRL, ROWS[i].ctrl);
      if (!ROWS[i].tx)
        rd_chk("rx data", ADDR_DATA, ROWS[i].ch[7:0]);
    end
    bus(1'h1, 8'h00, 8'hFF);
    rd_chk("unmapped", 8'h00, 8'h00);
    rd_chk("ctrl kept", ADDR_CTRL, 8'hBC);
    bus(1'h1, ADDR_CTRL, 8'hFC);
    irq_chk(2'h3);
    bus(1'h1, ADDR_CTRL, 8'h0C);
    irq_chk(2'h0);
    bus(1'h1, ADDR_CTRL, 8'h3D);
    n = u_node.rx_count;
    fork
      u_node.send_char(9'h0AA);
      begin
        repeat (800) @(posedge clk);
        bus(1'h1, ADDR_DATA, 8'h81);
      end
    join
    wait_for(1'h1);
    sent_chk(9'h181);
    chk("rx irq", 16'h0, 16'(rx_irq));
    rd_chk("ctrl abort", ADDR_CTRL, 8'h7D);
    rd_chk("buf abort", ADDR_DATA, 8'hC5);
    // Port bit low so the start bit shows as the only high stretch
    port_data_bit <= 1'h0;
    @(posedge clk);
    for (int c = 7; c < 15; c++)
    begin
      bus(1'h1, ADDR_CTRL, {4'h1, 3'(c), 1'h1});
      bus(1'h1, ADDR_DATA, 8'hFF);
      k = 0;
      repeat (7000)
      begin
        @(negedge clk);
        if (serial_out_pin === 1'h1)
          k++;
        else if (k > 0)
          break;
      end
      chk("start length", 16'(DIV_TAB[c % 8]), 16'(k));
      @(posedge clk);
    end
    wait_for(1'h1);
    port_data_bit <= 1'h1;
    @(posedge clk);
    end_sim();
  end
endmodule : hdu_uart_bench
